//--- common/pdm_pkg.sv
/*
  pdm_pkg: constants, types and register layout for the process data mapping broker.
  Assumes a single clock domain; all users refer to names as pdm_pkg::name.
*/
`default_nettype none
package pdm_pkg;
  localparam int unsigned CLK_HZ         = 200000000;
  localparam int unsigned NUM_PROD       = 3;
  localparam int unsigned NUM_SIMPLE     = 8;
  localparam int unsigned NUM_EXT        = 16;
  localparam int unsigned MAX_EXT_BITS   = 1024;
  localparam int unsigned MEM_WORDS      = 256;
  localparam int unsigned MEM_AW         = 8;
  localparam logic [15:0] SWAP_FLAG      = 16'h8000;
  localparam logic [16:0] MODBUS_FIRST   = 17'h00001;
  localparam logic [16:0] MODBUS_LAST    = 17'h10000;
  // store map in word indices: three input areas, three output areas
  localparam logic [7:0]  IN_BASE0       = 8'h00;
  localparam logic [7:0]  IN_BASE1       = 8'h20;
  localparam logic [7:0]  IN_BASE2       = 8'h40;
  localparam logic [7:0]  OUT_BASE0      = 8'h80;
  localparam logic [7:0]  OUT_BASE1      = 8'ha0;
  localparam logic [7:0]  OUT_BASE2      = 8'hc0;
  localparam logic [7:0]  AREA_WORDS     = 8'h20;
  // wishbone byte addresses
  localparam logic [11:0] ADR_CTRL       = 12'h000;
  localparam logic [11:0] ADR_STATUS     = 12'h004;
  localparam logic [11:0] ADR_IRQ_STAT   = 12'h008;
  localparam logic [11:0] ADR_IRQ_MASK   = 12'h00c;
  localparam logic [11:0] ADR_POLICY     = 12'h010;
  localparam logic [11:0] ADR_VALID0     = 12'h020;
  localparam logic [11:0] ADR_SMAP       = 12'h100;
  localparam logic [11:0] ADR_XMAP_A     = 12'h200;
  localparam logic [11:0] ADR_XMAP_B     = 12'h300;
  localparam logic [11:0] ADR_MEM        = 12'h800;
  localparam int unsigned STAT_W         = 4;
  localparam int unsigned IRQ_CYCLE      = 3;
  localparam logic [31:0] RESET_VALID    = 32'h00000000;
  typedef enum logic [1:0] {PDM_ZERO, PDM_ONES, PDM_HOLD} pdm_policy_t;
  typedef struct packed {
    logic        swap;
    logic [1:0]  src_if;
    logic [4:0]  src_off;
    logic [5:0]  len;
  } pdm_smap_t;
  typedef struct packed {
    logic        en;
    logic [7:0]  src_word;
    logic [3:0]  src_bit;
    logic [7:0]  dst_word;
    logic [3:0]  dst_bit;
    logic [10:0] count;
  } pdm_xmap_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [31:0] dat;
  } pdm_wb_req_t;
endpackage
`default_nettype wire

//--- logic/pdm_broker.sv
/*
  pdm_broker: cyclic copy engine over a store of 16-bit registers with simple and
  extended mapping, producer validity timers and substitute-data policies.
  Assumes a classic wishbone master on clk_i and producers pulsing fresh_i.
*/
// Notes on behaviour
// - the store holds individually addressed registers of sixteen bits each.
// - register numbers count from one as in Modbus; only a subset exists.
// - byte values use one register; 32-bit values use two registers.
// - registers keep low byte first; bus access presents that order.
// - each output area has eight entries copied from equal-length input areas.
// - simple targets pack back to back from the area's lowest register.
// - a failed producer's simple targets receive substitute values; extended targets keep their value, or still get copies when policy[0] is hold.
// - entries flagged with bit 15 swap high and low bytes of each word.
// - extended mapping has sixteen entries copying consecutive bit runs.
// - bit count at most 1024 and never beyond the store's end; the code stops only the target run there, a source run wraps to word 0.
// - extended targets and sources are register plus start bit 0 to 15.
// - simple entries run first, then extended; later writes may overwrite.
// - each of three producers has its own validity period.
// - deliveries restart a producer timer; expiry marks its data invalid.
// - each consumer picks zeros, ones or hold-last for invalid data.
// - periods and policies sit in retained configuration registers.
`default_nettype none
module pdm_broker (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  fresh_i,
  output logic      [2:0]  valid_o,
  output logic             irq_o
);
  typedef enum {ST_IDLE, ST_SIMPLE, ST_EXT} pdm_state_t;

  logic [15:0]        mem [pdm_pkg::MEM_WORDS];
  pdm_pkg::pdm_smap_t smap [3][pdm_pkg::NUM_SIMPLE];
  pdm_pkg::pdm_xmap_t xmap [pdm_pkg::NUM_EXT];
  logic [31:0]        period [3];
  logic [31:0]        timer [3];
  logic [1:0]         policy [3];
  logic [2:0]         valid;
  logic [2:0]         was_valid;
  logic               run;
  logic [3:0]         irq_stat;
  logic [3:0]         irq_mask;
  logic [31:0]        cycles;
  pdm_state_t         state;
  logic [1:0]         cons;
  logic [3:0]         ent;
  logic [5:0]         wcnt;
  logic [7:0]         dptr;
  logic [10:0]        bcnt;
  logic [11:0]        sbit;
  logic [11:0]        dbit;
  logic               cyc_done;

  function automatic logic [7:0] in_base(input logic [1:0] i);
    return (i == 2'd0) ? pdm_pkg::IN_BASE0 : (i == 2'd1) ? pdm_pkg::IN_BASE1 : pdm_pkg::IN_BASE2;
  endfunction
  function automatic logic [7:0] out_base(input logic [1:0] i);
    return (i == 2'd0) ? pdm_pkg::OUT_BASE0 : (i == 2'd1) ? pdm_pkg::OUT_BASE1 :
                         pdm_pkg::OUT_BASE2;
  endfunction
  function automatic logic [1:0] prod_of(input logic [7:0] w);
    return (w < pdm_pkg::IN_BASE1) ? 2'd0 : (w < pdm_pkg::IN_BASE2) ? 2'd1 : 2'd2;
  endfunction

  // bus decode
  logic        req;
  logic        wr;
  logic [11:0] a;
  logic [15:0] wdat16;
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = req && wb_we_i;
  assign a      = wb_adr_i;
  // low byte sits in lane 0 so bus order follows store order
  assign wdat16 = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                   wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

  // simple-pass source/target words
  pdm_pkg::pdm_smap_t se;
  logic [7:0]  s_src;
  logic [7:0]  s_dst;
  logic [15:0] s_raw;
  logic [15:0] s_val;
  logic [1:0]  s_prod;
  assign se     = smap[cons][ent[2:0]];
  assign s_src  = in_base(se.src_if) + {3'h0, se.src_off} + {2'h0, wcnt};
  assign s_dst  = dptr;
  assign s_raw  = se.swap ? {mem[s_src][7:0], mem[s_src][15:8]} : mem[s_src];
  // code 3 reads the fieldbus area, so judge it by that producer
  assign s_prod = (se.src_if == 2'd3) ? 2'd2 : se.src_if;
  always_comb begin
    unique case (policy[cons])
      2'd0:    s_val = valid[s_prod] ? s_raw : 16'h0000;
      2'd1:    s_val = valid[s_prod] ? s_raw : 16'hffff;
      default: s_val = valid[s_prod] ? s_raw : mem[s_dst];
    endcase
  end

  // extended-pass bit step
  pdm_pkg::pdm_xmap_t xe;
  logic        x_bit;
  logic        x_in_range;
  assign xe         = xmap[ent];
  assign x_bit      = mem[sbit[11:4]][sbit[3:0]];
  assign x_in_range = (sbit[11:4] < pdm_pkg::MEM_WORDS) && (dbit[11:4] >= pdm_pkg::OUT_BASE0)
                      && (bcnt < pdm_pkg::MAX_EXT_BITS);

  // sequencer
  always_ff @(posedge clk_i) begin
    cyc_done <= 1'b0;
    if (rst_i) begin
      state <= ST_IDLE;
      cons  <= 2'd0;
      ent   <= 4'd0;
      wcnt  <= 6'd0;
      dptr  <= pdm_pkg::OUT_BASE0;
      bcnt  <= 11'd0;
      sbit  <= 12'h000;
      dbit  <= 12'h000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (run) begin
            state <= ST_SIMPLE;
            cons  <= 2'd0;
            ent   <= 4'd0;
            wcnt  <= 6'd0;
            dptr  <= out_base(2'd0);
          end
        end
        ST_SIMPLE: begin
          if (wcnt + 6'd1 < se.len && dptr + 8'd1 < out_base(cons) + pdm_pkg::AREA_WORDS) begin
            wcnt <= wcnt + 6'd1;
            dptr <= dptr + 8'd1;
          end else begin
            wcnt <= 6'd0;
            if (se.len != 6'd0) begin
              dptr <= dptr + 8'd1;
            end
            if (ent[2:0] == 3'd7) begin
              ent <= 4'd0;
              if (cons == 2'd2) begin
                state <= ST_EXT;
                bcnt  <= 11'd0;
                sbit  <= {xmap[0].src_word, xmap[0].src_bit};
                dbit  <= {xmap[0].dst_word, xmap[0].dst_bit};
              end else begin
                cons <= cons + 2'd1;
                dptr <= out_base(cons + 2'd1);
              end
            end else begin
              ent <= ent + 4'd1;
            end
          end
        end
        ST_EXT: begin
          if (xe.en && bcnt + 11'd1 < xe.count && x_in_range && dbit != 12'hfff) begin
            bcnt <= bcnt + 11'd1;
            sbit <= sbit + 12'h001;
            dbit <= dbit + 12'h001;
          end else if (ent == 4'd15) begin
            state    <= run ? ST_SIMPLE : ST_IDLE;
            cyc_done <= 1'b1;
            ent      <= 4'd0;
            cons     <= 2'd0;
            dptr     <= out_base(2'd0);
          end else begin
            ent  <= ent + 4'd1;
            bcnt <= 11'd0;
            sbit <= {xmap[ent + 4'd1].src_word, xmap[ent + 4'd1].src_bit};
            dbit <= {xmap[ent + 4'd1].dst_word, xmap[ent + 4'd1].dst_bit};
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // store: bus writes first, engine writes after so the copy wins a collision
  always_ff @(posedge clk_i) begin
    if (wr && a >= pdm_pkg::ADR_MEM) begin
      mem[a[9:2]] <= wdat16;
    end
    if (state == ST_SIMPLE && se.len != 6'd0 &&
        s_dst < out_base(cons) + pdm_pkg::AREA_WORDS) begin
      mem[s_dst] <= s_val;
    end
    if (state == ST_EXT && xe.en && xe.count != 11'd0 && x_in_range &&
        (valid[prod_of(sbit[11:4])] || policy[2'd0] == 2'd2)) begin
      mem[dbit[11:4]][dbit[3:0]] <= x_bit;
    end
  end

  // validity timers
  for (genvar p = 0; p < 3; p++) begin : g_prod
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        timer[p] <= 32'h00000000;
        valid[p] <= 1'b0;
      end else if (fresh_i[p]) begin
        timer[p] <= 32'h00000000;
        valid[p] <= 1'b1;
      end else if (period[p] != 32'h00000000 && valid[p]) begin
        if (timer[p] + 32'h1 >= period[p]) begin
          valid[p] <= 1'b0;
        end else begin
          timer[p] <= timer[p] + 32'h1;
        end
      end
    end
  end

  // configuration: held across soft restarts, only cleared by rst_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= 1'b1;
      for (int i = 0; i < 3; i++) begin
        period[i] <= pdm_pkg::RESET_VALID;
        policy[i] <= 2'd0;
        for (int j = 0; j < 8; j++) begin
          smap[i][j] <= '0;
        end
      end
      for (int k = 0; k < 16; k++) begin
        xmap[k] <= '0;
      end
    end else if (wr) begin
      if (a == pdm_pkg::ADR_CTRL && wb_sel_i[0]) begin
        run <= wb_dat_i[0];
      end
      if (a == pdm_pkg::ADR_POLICY && wb_sel_i[0]) begin
        policy[0] <= (wb_dat_i[1:0] == 2'd3) ? 2'd2 : wb_dat_i[1:0];
        policy[1] <= (wb_dat_i[3:2] == 2'd3) ? 2'd2 : wb_dat_i[3:2];
        policy[2] <= (wb_dat_i[5:4] == 2'd3) ? 2'd2 : wb_dat_i[5:4];
      end
      if (a[11:4] == pdm_pkg::ADR_VALID0[11:4] && a[3:2] != 2'd3) begin
        period[a[3:2]] <= wb_dat_i;
      end
      if (a[11:8] == pdm_pkg::ADR_SMAP[11:8] && a[7:5] < 3'd3) begin
        smap[a[6:5]][a[4:2]] <= '{swap: wb_dat_i[15], src_if: wb_dat_i[14:13],
                                  src_off: wb_dat_i[12:8], len: wb_dat_i[5:0]};
      end
      if (a[11:8] == pdm_pkg::ADR_XMAP_A[11:8] && a[7:6] == 2'd0) begin
        xmap[a[5:2]].en       <= wb_dat_i[31];
        xmap[a[5:2]].src_word <= wb_dat_i[23:16];
        xmap[a[5:2]].src_bit  <= wb_dat_i[15:12];
        xmap[a[5:2]].dst_word <= wb_dat_i[11:4];
        xmap[a[5:2]].dst_bit  <= wb_dat_i[3:0];
      end
      if (a[11:8] == pdm_pkg::ADR_XMAP_B[11:8] && a[7:6] == 2'd0) begin
        xmap[a[5:2]].count <= (wb_dat_i[10:0] > 11'd1024) ? 11'd1024 : wb_dat_i[10:0];
      end
    end
  end

  // interrupts: bits 0..2 producer lost, bit 3 cycle done; set beats clear
  logic [3:0] ev;
  assign ev = {cyc_done, was_valid & ~valid};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat  <= 4'h0;
      irq_mask  <= 4'h0;
      was_valid <= 3'h0;
      cycles    <= 32'h00000000;
      irq_o     <= 1'b0;
      valid_o   <= 3'h0;
    end else begin
      was_valid <= valid;
      valid_o   <= valid;
      if (cyc_done) begin
        cycles <= cycles + 32'h1;
      end
      if (wr && a == pdm_pkg::ADR_IRQ_MASK) begin
        irq_mask <= wb_dat_i[3:0];
      end
      irq_stat <= (irq_stat & ~((wr && a == pdm_pkg::ADR_IRQ_STAT) ? wb_dat_i[3:0] : 4'h0)) | ev;
      irq_o    <= |(irq_stat & irq_mask);
    end
  end

  // bus answer: one-cycle ack, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h00000000;
      if (req && !wb_we_i) begin
        if (a >= pdm_pkg::ADR_MEM) begin
          wb_dat_o <= {16'h0000, mem[a[9:2]]};
        end else begin
          unique case (a)
            pdm_pkg::ADR_CTRL:     wb_dat_o <= {31'h0, run};
            pdm_pkg::ADR_STATUS:   wb_dat_o <= {cycles[27:0], state == ST_IDLE, valid};
            pdm_pkg::ADR_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat};
            pdm_pkg::ADR_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask};
            pdm_pkg::ADR_POLICY:   wb_dat_o <= {26'h0, policy[2], policy[1], policy[0]};
            12'h020:               wb_dat_o <= period[0];
            12'h024:               wb_dat_o <= period[1];
            12'h028:               wb_dat_o <= period[2];
            default:               wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/pdm_broker_properties.sv
/* port checker for pdm_broker.
   bound onto the broker; sees its ports only, one clock. */
`default_nettype none
module pdm_broker_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  fresh_i,
  input wire logic [2:0]  valid_o,
  input wire logic        irq_o
);
  logic [2:0] seen;
  wire        req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // producers seen since reset; valid may never run ahead of them
  always_ff @(posedge clk_i) seen <= rst_i ? 3'h0 : (seen | fresh_i);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  a_unmapped_zero: assert property (
    req && !wb_we_i && wb_adr_i == 12'h7f0 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property ($fell(rst_i) |-> valid_o == 3'h0 && !wb_ack_o && !irq_o)
    else $error("outputs not quiet after reset");
  a_start_invalid: assert property ((valid_o & ~seen) == 3'h0)
    else $error("valid before any delivery");
  for (genvar k = 0; k < 3; k++) begin : g_prod
    a_fresh_valid: assert property (fresh_i[k] |-> ##2 valid_o[k])
      else $error("delivery did not make producer valid");
    a_valid_rise: assert property ($rose(valid_o[k]) |-> $past(fresh_i[k], 2))
      else $error("valid rose without delivery");
  end
endmodule
bind pdm_broker pdm_broker_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fresh_i(fresh_i), .valid_o(valid_o),
  .irq_o(irq_o));
`default_nettype wire

//--- sim/pdm_producer_model.sv
/* producer model: one delivery pulse per enabled producer every gap_i + 1 cycles.
   assumes the broker clock and reset. */
`default_nettype none
module pdm_producer_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] run_i,
  input  wire logic [7:0] gap_i,
  output logic      [2:0] fresh_o
);
  logic [7:0] cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt >= gap_i) cnt <= 8'h0;
    else cnt <= cnt + 8'h1;
  end
  // a stopped producer goes silent, never a held pulse
  always_ff @(posedge clk_i) fresh_o <= (!rst_i && cnt == 8'h0) ? run_i : 3'h0;
endmodule
`default_nettype wire

//--- sim/pdm_broker_tb_top.sv
/* bench for pdm_broker: wishbone tasks, producer model, reference model.
   assumes the map of pdm_pkg and one 200 MHz clock. */
`default_nettype none
module pdm_broker_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  pdm_pkg::pdm_wb_req_t req = '0;
  logic [3:0]           sel = 4'h0;
  logic [3:0]           wsel = 4'hf;
  logic [31:0]          dat_o, rd, seed = 32'h4136;
  logic                 ack, irq;
  logic [2:0]           fresh, valid, run = 3'h0;
  logic [15:0]          inw [2][4];
  int                   n_mismatch = 0, n_compared = 0, pol = 2, n;
  int                   pval [3] = '{1, 1, 1}, sif [2] = '{1, 0};
  int                   soff [2] = '{2, 0}, slen [2] = '{2, 1};
  always #2.5 clk_i = ~clk_i;
  pdm_broker u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(sel), .wb_dat_i(req.dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .fresh_i(fresh), .valid_o(valid), .irq_o(irq));
  pdm_producer_model u_prod (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .gap_i(8'd20),
    .fresh_o(fresh));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [11:0] madr(input logic [7:0] i);
    return pdm_pkg::ADR_MEM + {2'b00, i, 2'b00};
  endfunction
  // consumer0 word i: entry0 swapped from producer1, entry1 from producer0
  function automatic logic [15:0] exp_out(input int i);
    int p;
    logic [15:0] w;
    p = 0;
    exp_out = 16'h0;
    for (int e = 0; e < 2; e++) begin
      for (int k = 0; k < slen[e]; k++) begin
        w = inw[sif[e]][soff[e] + k];
        if (e == 0) w = {w[7:0], w[15:8]};
        if (pval[sif[e]] == 0 && pol != 2) w = (pol == 1) ? 16'hffff : 16'h0;
        if (p == i) exp_out = w;
        p++;
      end
    end
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, d};
    sel <= wsel;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    rd = dat_o;
    req <= '0;
    sel <= 4'h0;
    check(ack, 1'b1);
  endtask
  // two cycle-done marks, so a full pass ran after any change
  task automatic sync;
    int t;
    // running producers must be valid first, else a pass may copy stale data
    @(posedge clk_i);
    t = 0;
    while (valid !== run && t < 100) begin
      @(posedge clk_i);
      t++;
    end
    check(valid, run);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, pdm_pkg::ADR_IRQ_STAT, 32'h8);
      t = 0;
      do begin
        bus(1'b0, pdm_pkg::ADR_IRQ_STAT, 32'h0);
        t++;
      end while (rd[3] !== 1'b1 && t < 500);
      check(rd[3], 1'b1);
    end
  endtask
  task automatic check_out;
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, madr(8'(8'h80 + i)), 32'h0);
      check(rd[15:0], exp_out(i));
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(valid, 3'h0);
    bus(1'b0, 12'h7f0, 32'h0);
    check(rd, 32'h0);
    wsel = 4'h1;
    bus(1'b1, madr(8'h60), 32'h1234abcd);
    wsel = 4'hf;
    bus(1'b0, madr(8'h60), 32'h0);
    check(rd, 32'h000000cd);
    bus(1'b1, pdm_pkg::ADR_VALID0 + 12'h4, 32'd60);
    bus(1'b0, pdm_pkg::ADR_VALID0 + 12'h4, 32'h0);
    check(rd, 32'd60);
    bus(1'b1, pdm_pkg::ADR_SMAP, 32'ha202);
    bus(1'b1, pdm_pkg::ADR_SMAP + 12'h4, 32'h0001);
    bus(1'b1, pdm_pkg::ADR_XMAP_A, 32'h80004a1c);
    bus(1'b1, pdm_pkg::ADR_XMAP_B, 32'd8);
    bus(1'b1, pdm_pkg::ADR_POLICY, 32'd2);
    bus(1'b1, madr(8'ha1), 32'h0);
    bus(1'b1, madr(8'ha2), 32'h0);
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        inw[p][i] = seed[15:0];
        bus(1'b1, madr(8'(32 * p + i)), {16'h0, seed[15:0]});
      end
    end
    run <= 3'h7;
    sync();
    check(valid, 3'h7);
    bus(1'b0, madr(8'h00), 32'h0);
    check(rd[15:0], inw[0][0]);
    check_out();
    bus(1'b0, madr(8'ha1), 32'h0);
    check(rd[15:0], {inw[0][0][7:4], 12'h0});
    bus(1'b0, madr(8'ha2), 32'h0);
    check(rd[15:0], {12'h0, inw[0][0][11:8]});
    bus(1'b1, pdm_pkg::ADR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk_i);
    check(irq, 1'b0);
    run <= 3'b101;
    pval[1] = 0;
    n = 0;
    while (valid[1] !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check(valid, 3'b101);
    repeat (3) @(posedge clk_i);
    check(irq, 1'b1);
    bus(1'b1, pdm_pkg::ADR_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk_i);
    check(irq, 1'b0);
    for (int j = 0; j < 3; j++) begin
      pol = (j + 2) % 3;
      bus(1'b1, pdm_pkg::ADR_POLICY, 32'(pol));
      sync();
      check_out();
    end
    run <= 3'h7;
    pval[1] = 1;
    sync();
    check_out();
    finish_test();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
